// >>> vsad_addr_match.sv
// Compares a cycle address with the selected base or slot address.
`timescale 1ns/1ps
`include "vsad_cfg.svh"
module vsad_addr_match
  import vsad_pkg::*;
(
  input vsad_space_t space_i, // Recognised space.
  input wire logic [31:0] addr_i, // Cycle address.
  input wire logic [15:0] base_i, // Selected base bits A31..A16.
  input wire logic [4:0] slot_i, // Latched slot number.
  input wire logic slot_ok_i, // Slot lines exist on this variant.
  input wire logic outbuf_i, // Offset targets the output data buffer.
  output logic hit_o // Address is ours.
);
  // A24 ignores A31..A24; slot space also needs A18..A16 zero.
  always_comb begin
    hit_o = 1'b0;
    unique case (space_i)
      VSAD_SP_A24: hit_o = (addr_i[23:16] == base_i[7:0]);
      VSAD_SP_A32: hit_o = (addr_i[31:16] == base_i);
      VSAD_SP_SLOT: hit_o = slot_ok_i && !outbuf_i && (addr_i[23:19] == slot_i)
        && (addr_i[18:16] == 3'h0);
      VSAD_SP_NONE: hit_o = 1'b0;
      default: hit_o = 1'b0;
    endcase
  end
endmodule

// >>> vsad_am_decode.sv
// Address-modifier classifier: address space and transfer kind.
`timescale 1ns/1ps
`include "vsad_cfg.svh"
module vsad_am_decode
  import vsad_pkg::*;
(
  input wire logic [5:0] am_i, // Address modifier code.
  output vsad_space_t space_o, // Recognised space.
  output vsad_xfer_t xfer_o // Transfer kind.
);
  // Any code not listed leaves the space at none.
  always_comb begin
    space_o = VSAD_SP_NONE;
    xfer_o = VSAD_XF_SINGLE;
    unique case (am_i)
      `VSAD_AM_A24_DAT_SUP, `VSAD_AM_A24_DAT_USR: space_o = VSAD_SP_A24;
      `VSAD_AM_A24_BLT_SUP, `VSAD_AM_A24_BLT_USR: begin
        space_o = VSAD_SP_A24;
        xfer_o = VSAD_XF_BLT;
      end
      `VSAD_AM_A24_MBLT_SUP, `VSAD_AM_A24_MBLT_USR: begin
        space_o = VSAD_SP_A24;
        xfer_o = VSAD_XF_MBLT;
      end
      `VSAD_AM_SLOT_SPACE: space_o = VSAD_SP_SLOT;
      `VSAD_AM_A32_DAT_SUP, `VSAD_AM_A32_DAT_USR: space_o = VSAD_SP_A32;
      `VSAD_AM_A32_BLT_SUP, `VSAD_AM_A32_BLT_USR: begin
        space_o = VSAD_SP_A32;
        xfer_o = VSAD_XF_BLT;
      end
      `VSAD_AM_A32_MBLT_SUP, `VSAD_AM_A32_MBLT_USR: begin
        space_o = VSAD_SP_A32;
        xfer_o = VSAD_XF_MBLT;
      end
      default: space_o = VSAD_SP_NONE;
    endcase
  end
endmodule

// >>> vsad_cfg.svh
// Constants for the slave address decoder: offsets, field positions, codes and reset values.
`ifndef VSAD_CFG_SVH
`define VSAD_CFG_SVH
`define VSAD_OFF_CTRL 8'h00
`define VSAD_OFF_BASE_HI 8'h04
`define VSAD_OFF_BASE_LO 8'h08
`define VSAD_OFF_SLOT 8'h0C
`define VSAD_OFF_STATUS 8'h10
`define VSAD_CTRL_REG_BASE_BIT 4
`define VSAD_CTRL_OUTBUF_BIT 0
`define VSAD_CTRL_RESET 32'h0000_0000
`define VSAD_BASE_RESET 8'h00
`define VSAD_SLOT_RESET 5'h00
`define VSAD_AM_A24_BLT_SUP 6'h3F
`define VSAD_AM_A24_DAT_SUP 6'h3D
`define VSAD_AM_A24_MBLT_SUP 6'h3C
`define VSAD_AM_A24_BLT_USR 6'h3B
`define VSAD_AM_A24_DAT_USR 6'h39
`define VSAD_AM_A24_MBLT_USR 6'h38
`define VSAD_AM_SLOT_SPACE 6'h2F
`define VSAD_AM_A32_BLT_SUP 6'h0F
`define VSAD_AM_A32_DAT_SUP 6'h0D
`define VSAD_AM_A32_MBLT_SUP 6'h0C
`define VSAD_AM_A32_BLT_USR 6'h0B
`define VSAD_AM_A32_DAT_USR 6'h09
`define VSAD_AM_A32_MBLT_USR 6'h08
`endif

// >>> vsad_chk.sv
// Checker for the slave address decoder outputs.
`timescale 1ns/1ps
module vsad_chk
  import vsad_pkg::*;
#(
  parameter int OUTBUF_LIMIT = 16'h1000 // Output buffer offsets lie below this.
) (
  input wire logic sys_clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input vsad_cycle_t cycle_i, // Cycle under decode.
  input vsad_match_t match_o, // Decode result.
  input wire logic dtack_en_o // Acknowledge enable.
);
  // All checks sample on the clock and pause during reset.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Every hit traces back to an accepted modifier one cycle earlier; only slot hits are also checked against an accepted address.
  property p_a24; match_o.hit && match_o.space == VSAD_SP_A24
    |-> $past(cycle_i.am) inside {6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38}; endproperty
  a_a24: assert property (p_a24) else $error("A24 hit with a foreign modifier.");
  property p_a32; match_o.hit && match_o.space == VSAD_SP_A32
    |-> $past(cycle_i.am) inside {6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08}; endproperty
  a_a32: assert property (p_a32) else $error("A32 hit with a foreign modifier.");
  property p_slot; match_o.hit && match_o.space == VSAD_SP_SLOT |-> $past(cycle_i.am) == 6'h2F; endproperty
  a_slot: assert property (p_slot) else $error("Slot hit without modifier 2F.");
  property p_outbuf; match_o.hit && match_o.space == VSAD_SP_SLOT |-> $past(cycle_i.addr[15:0]) >= OUTBUF_LIMIT;
  endproperty
  a_outbuf: assert property (p_outbuf) else $error("Slot hit on the output buffer.");
  property p_slot_addr; match_o.hit && match_o.space == VSAD_SP_SLOT |-> $past(cycle_i.addr[18:16]) == 3'h0;
  endproperty
  a_slot_addr: assert property (p_slot_addr) else $error("Slot hit with nonzero A18..A16.");
  property p_offset; match_o.hit |-> dtack_en_o && match_o.offset == $past(cycle_i.addr[15:0]); endproperty
  a_offset: assert property (p_offset) else $error("Offset or acknowledge wrong on a hit.");
  property p_mblt; match_o.hit && match_o.xfer == VSAD_XF_MBLT && match_o.space != VSAD_SP_SLOT
    |-> $past(cycle_i.am) inside {6'h3C, 6'h38, 6'h0C, 6'h08}; endproperty
  a_mblt: assert property (p_mblt) else $error("64-bit block kind from another modifier.");
  property p_idle; !$past(cycle_i.valid) |-> !match_o.hit && !dtack_en_o; endproperty
  a_idle: assert property (p_idle) else $error("Acknowledge without a cycle.");
endmodule
bind vsad_top vsad_chk #(.OUTBUF_LIMIT(OUTBUF_LIMIT)) vsad_chk_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .cycle_i(cycle_i), .match_o(match_o), .dtack_en_o(dtack_en_o));

// >>> vsad_pkg.sv
// Types shared by the slave address decoder modules.
package vsad_pkg;
  typedef enum logic [2:0] {
    VSAD_SP_NONE,
    VSAD_SP_A24,
    VSAD_SP_A32,
    VSAD_SP_SLOT
  } vsad_space_t;
  typedef enum logic [1:0] {
    VSAD_XF_SINGLE,
    VSAD_XF_BLT,
    VSAD_XF_MBLT
  } vsad_xfer_t;
  typedef struct packed {
    logic [5:0] am;
    logic [31:0] addr;
    logic valid;
  } vsad_cycle_t;
  typedef struct packed {
    logic hit;
    vsad_space_t space;
    vsad_xfer_t xfer;
    logic [15:0] offset;
  } vsad_match_t;
endpackage

// >>> vsad_top.sv
// Slave address decoder: APB control registers, base selection, slot latch and match.
// Operation
// - Accept A24 modifiers 3F, 3D, 3C, 3B, 39 and 38.
// - Accept A32 modifiers 0F, 0D, 0C, 0B, 09 and 08.
// - Slot-based accesses only with modifier 2F in A24 form.
// - Base selectable over upper address bits; low 16 bits are offset.
// - Control bit 4 clear selects rotary switches; resets clear.
// - Control bit 4 set selects the programmable base registers.
// - High base register gives A31..A24, low gives A23..A16.
// - Slot accesses reach all registers except the output data buffer.
// - Slot number latched from slot_id_lines at every reset.
// - Slot address: A23..A19 slot, A18..A16 zero, A15..A0 offset.
// - Without slot lines slot addressing is off; written value never matches.
// - Support single, block and 64-bit block transfers.
`timescale 1ns/1ps
`include "vsad_cfg.svh"
module vsad_top
  import vsad_pkg::*;
#(
  parameter int OUTBUF_LIMIT = 16'h1000 // Offsets below this are the output data buffer.
) (
  input wire logic sys_clk_i, // 50 MHz clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic [15:0] rotary_i, // Four rotary switches, A31..A16.
  input wire logic [4:0] slot_id_lines_i, // Backplane slot number.
  input wire logic aux_backplane_connector_i, // High when slot lines exist.
  input vsad_cycle_t cycle_i, // Bus cycle under decode.
  output vsad_match_t match_o, // Registered decode result.
  output logic dtack_en_o // Acknowledge may be given.
);
  // Refuse a limit that no 16-bit offset can reach, at elaboration.
  if (OUTBUF_LIMIT < 1 || OUTBUF_LIMIT > 32'h0000_FFFF) begin : g_bad_limit
    $error("OUTBUF_LIMIT out of range");
  end

  // Control reset word, kept whole so that one bit can be picked from it.
  localparam logic [31:0] CTRL_RESET = `VSAD_CTRL_RESET;

  typedef struct packed {
    logic reg_base;
    logic [7:0] base_hi;
    logic [7:0] base_lo;
    logic [4:0] slot_sw;
    logic [4:0] slot_hw;
    logic slot_hw_ok;
    logic capture;
    vsad_match_t match;
    logic [31:0] rdata;
  } vsad_state_t;

  vsad_state_t s_q;
  vsad_state_t s_d;
  vsad_space_t space;
  vsad_xfer_t xfer;
  logic hit;
  logic [15:0] base_sel;
  logic [4:0] slot_sel;
  logic outbuf;
  logic apb_acc;
  logic mapped;

  // Modifier classification.
  vsad_am_decode u_am (
    .am_i(cycle_i.am),
    .space_o(space),
    .xfer_o(xfer)
  );

  // Base source choice between switches and registers.
  assign base_sel = s_q.reg_base ? {s_q.base_hi, s_q.base_lo} : rotary_i;
  // Only the latched backplane slot steers matching, never the written copy.
  assign slot_sel = s_q.slot_hw;
  assign outbuf = ({16'h0000, cycle_i.addr[15:0]} < 32'(OUTBUF_LIMIT));

  // Address comparison.
  vsad_addr_match u_match (
    .space_i(space),
    .addr_i(cycle_i.addr),
    .base_i(base_sel),
    .slot_i(slot_sel),
    .slot_ok_i(s_q.slot_hw_ok),
    .outbuf_i(outbuf),
    .hit_o(hit)
  );

  // APB decode; answer in the first access cycle.
  assign apb_acc = psel && penable;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      `VSAD_OFF_CTRL, `VSAD_OFF_BASE_HI, `VSAD_OFF_BASE_LO, `VSAD_OFF_SLOT, `VSAD_OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = apb_acc && !mapped;
  assign prdata = s_q.rdata;

  // Next-state logic for all registers.
  always_comb begin
    s_d = s_q;
    s_d.capture = 1'b0;
    // Slot number is caught on the first edge after reset release.
    if (s_q.capture) begin
      s_d.slot_hw = slot_id_lines_i;
      s_d.slot_hw_ok = aux_backplane_connector_i;
    end
    // Register writes.
    if (psel && !penable && pwrite) begin
      s_d.rdata = 32'h0000_0000;
    end
    if (apb_acc && pwrite) begin
      unique case (paddr)
        `VSAD_OFF_CTRL: s_d.reg_base = pwdata[`VSAD_CTRL_REG_BASE_BIT];
        `VSAD_OFF_BASE_HI: s_d.base_hi = pwdata[7:0];
        `VSAD_OFF_BASE_LO: s_d.base_lo = pwdata[7:0];
        `VSAD_OFF_SLOT: begin
          if (!s_q.slot_hw_ok) begin
            s_d.slot_sw = pwdata[4:0];
          end
        end
        default: s_d.rdata = s_q.rdata;
      endcase
    end
    // Read data is prepared in the setup cycle.
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `VSAD_OFF_CTRL: s_d.rdata = {27'h0, s_q.reg_base, 4'h0};
        `VSAD_OFF_BASE_HI: s_d.rdata = {24'h0, s_q.base_hi};
        `VSAD_OFF_BASE_LO: s_d.rdata = {24'h0, s_q.base_lo};
        `VSAD_OFF_SLOT: s_d.rdata = {27'h0, s_q.slot_hw_ok ? s_q.slot_hw : s_q.slot_sw};
        `VSAD_OFF_STATUS: s_d.rdata = {10'h0, s_q.slot_hw_ok, s_q.slot_hw, base_sel};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Registered decode of the current cycle.
    s_d.match.hit = cycle_i.valid && hit;
    s_d.match.space = space;
    s_d.match.xfer = xfer;
    s_d.match.offset = cycle_i.addr[15:0];
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.reg_base <= CTRL_RESET[`VSAD_CTRL_REG_BASE_BIT];
      s_q.base_hi <= `VSAD_BASE_RESET;
      s_q.base_lo <= `VSAD_BASE_RESET;
      s_q.slot_sw <= `VSAD_SLOT_RESET;
      s_q.capture <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign match_o = s_q.match;
  assign dtack_en_o = s_q.match.hit;
endmodule

// >>> vsad_top_tb.sv
// Self-checking bench for the slave address decoder.
`timescale 1ns/1ps
module vsad_top_tb;
  import vsad_pkg::*;
  typedef struct {logic [5:0] am; logic [31:0] a; logic [5:0] x;} vsad_row_t;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, aux = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [4:0] slot = 5'h05;
  logic [15:0] rot = 16'hEE11;
  logic pready, pslverr, e, dtack;
  vsad_cycle_t cyc;
  vsad_match_t match;
  int miscompares = 0, n_compared = 0;
  vsad_row_t rows[19] = '{'{6'h3F, 32'h00112000, 6'h25}, '{6'h3D, 32'h00112000, 6'h24},
    '{6'h3C, 32'h00112000, 6'h26}, '{6'h3B, 32'h00112000, 6'h25}, '{6'h39, 32'h00112000, 6'h24},
    '{6'h38, 32'h00112000, 6'h26}, '{6'h0F, 32'hEE112000, 6'h29}, '{6'h0D, 32'hEE112000, 6'h28},
    '{6'h0C, 32'hEE112000, 6'h2A}, '{6'h0B, 32'hEE112000, 6'h29}, '{6'h09, 32'hEE112000, 6'h28},
    '{6'h08, 32'hEE112000, 6'h2A}, '{6'h2F, 32'h00281006, 6'h2C}, '{6'h2F, 32'h00280006, 6'h00},
    '{6'h2F, 32'h00291006, 6'h00}, '{6'h3D, 32'h00122000, 6'h00}, '{6'h0D, 32'hEF112000, 6'h00},
    '{6'h3E, 32'h00112000, 6'h00}, '{6'h2D, 32'h00112000, 6'h00}};
  // Clock of 20 ns.
  always #10 sys_clk_i = ~sys_clk_i;
  vsad_top vsad_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rotary_i(rot),
    .slot_id_lines_i(slot), .aux_backplane_connector_i(aux), .cycle_i(cyc), .match_o(match), .dtack_en_o(dtack));
  vsad_vme_mst vsad_vme_mst_i (.clk_i(sys_clk_i), .cyc_o(cyc));
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", n, x, g);
      miscompares++;
    end
  endtask
  // One APB transfer; the request stands until pready is seen high, or the run ends after 20 access cycles without it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask
  // Sends a cycle and compares hit, space and kind; kind is left open in slot space.
  task automatic run(input logic [5:0] am, input logic [31:0] a, input logic [5:0] x);
    vsad_vme_mst_i.cyc(am, a);
    #1;
    chk($sformatf("decode am %h addr %h", am, a), {26'h0, x}, {26'h0, match.hit,
      match.hit ? {match.space, match.space == VSAD_SP_SLOT ? 2'b00 : match.xfer} : 5'h00});
    chk("dtack", {31'h0, x[5]}, {31'h0, dtack});
    if (x[5]) chk("offset", {16'h0000, a[15:0]}, {16'h0000, match.offset});
  endtask
  // Reset for five cycles with the given slot lines.
  task automatic rst(input logic [4:0] s, input logic x);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    slot <= s;
    aux <= x;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
  endtask
  // Table first, then control, base registers and slot handling.
  initial begin
    rst(5'h05, 1'b1);
    foreach (rows[i]) run(rows[i].am, rows[i].a, rows[i].x);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, 8'h04, 32'hCC);
    apb(1'b1, 8'h08, 32'h22);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h04, 32'h0);
    chk("base hi", 32'hCC, q);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl set", 32'h10, q);
    run(6'h0D, 32'hCC220000, 6'h28);
    run(6'h39, 32'h00224000, 6'h24);
    run(6'h0D, 32'hEE110000, 6'h00);
    apb(1'b1, 8'h00, 32'h0);
    run(6'h0D, 32'hEE110000, 6'h28);
    @(posedge sys_clk_i);
    rot <= 16'h0033;
    run(6'h39, 32'h00332000, 6'h24);
    run(6'h0D, 32'h00330000, 6'h28);
    apb(1'b1, 8'h00, 32'h10);
    rst(5'h08, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl after reset", 32'h0, q);
    run(6'h2F, 32'h00401006, 6'h2C);
    run(6'h2F, 32'h00281006, 6'h00);
    rst(5'h05, 1'b0);
    apb(1'b1, 8'h0C, 32'h05);
    run(6'h2F, 32'h00281006, 6'h00);
    apb(1'b0, 8'h0C, 32'h0);
    chk("slot", 32'h05, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("status", 32'h0005_0033, q);
    final_report();
  end
endmodule

// >>> vsad_vme_mst.sv
// Behavioural bus master that presents cycles to the decoder.
`timescale 1ns/1ps
module vsad_vme_mst
  import vsad_pkg::*;
(
  input wire logic clk_i, // Clock.
  output vsad_cycle_t cyc_o // Cycle to the decoder.
);
  // Lines start idle.
  initial cyc_o = '{am: 6'h00, addr: 32'h0000_0000, valid: 1'b0};
  // One cycle per call; 24-bit forms carry junk above A23, released lines show the inverse.
  task automatic cyc(input logic [5:0] am, input logic [31:0] a);
    @(posedge clk_i);
    cyc_o <= '{am: am, addr: am[5] ? {8'h5A, a[23:0]} : a, valid: 1'b1};
    @(posedge clk_i);
    cyc_o <= '{am: ~am, addr: ~a, valid: 1'b0};
  endtask
endmodule
